/* File: src/simulcast_consts.svh */
// Register offsets, field positions, reset values and timing counts for the delay path control.
// Included by the package and by the control module; definitions only.
`ifndef SIMULCAST_CONSTS_SVH
`define SIMULCAST_CONSTS_SVH

// Register offsets on the plain register port
`define REG_AUD_DELAY_LO 4'h0
`define REG_AUD_DELAY_HI 4'h2
`define REG_AUD_ATTEN 4'h3
`define REG_ENC_ATTEN 4'h4
`define REG_FSK_ATTEN 4'h5
`define REG_CONTROL 4'h6
`define REG_STATUS 4'h7

// Control register fields
`define CTL_FOUR_LEVEL 0
`define CTL_DRIVER_TX 1
`define CTL_REMOTE_KEY 2
`define CTL_RESET_VAL 8'h00

// Reset values of the stored settings
`define DELAY_RESET_VAL 10'h000
`define ATTEN_RESET_VAL 8'h00

// Fixed attenuation in attenuator steps so that a 0 dB setting gives nominal level
`define ATTEN_OFFSET_STEPS 9'h03C

// Timing
`define CLK_HZ 40000000
`define REFRESH_US 1000
`define REFRESH_CYCLES ((`REFRESH_US * (`CLK_HZ / 1000000)))
`define SYMBOL_DELAY_MS 10
`define FIR_TAPS 28

`endif

/* File: src/simulcast_pkg.sv */
// Types shared by the delay path control.
// Assumes the constants header sits beside it in src/.
`include "simulcast_consts.svh"

package simulcast_pkg;
	typedef enum logic [1:0] {FILT_IN, FILT_OUT_EXT, FILT_OUT_INT, FILT_FORCED} filter_e;
	typedef logic signed [2:0] level_t;
	typedef logic [9:0] delay_t;
endpackage

/* File: src/simulcast_delay_path_control.sv */
// Delay, attenuator, path select, noise filter and symbol path control for a simulcast site.
// Assumes all inputs but arst_n are synchronous to clk_sys; sample and bit strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "simulcast_consts.svh"

module simulcast_delay_path_control #(
	parameter int SAMPLE_W = 12,
	parameter int DEPTH = 1024,
	parameter int BIT_RATE_HZ = 9600,
	parameter int REFRESH_CYCLES = `REFRESH_CYCLES,
	parameter int LS_MIN_EDGES = 2
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic sampleStrobe,
	input wire logic [SAMPLE_W-1:0] sampleIn,
	output logic [SAMPLE_W-1:0] sampleOut,
	input wire logic data_detect_input,
	input wire logic wide_area_talk_request,
	input wire logic site_controller_talk_request,
	input wire logic control_channel_indicator_in,
	input wire logic handshakeDataPresent,
	input wire logic external_filter_jumper,
	input wire logic filter_source_jumper,
	input wire logic fskDelayedData,
	input wire logic bitStrobe,
	input wire logic presignalSync,
	input wire logic symbol_low_bit_input,
	input wire logic symbol_high_bit_input,
	output logic data_detect_output,
	output logic transmitter_key_up_output,
	output logic encryptedSelect,
	output logic noiseFilterIn,
	output logic [8:0] audioAttenCode,
	output logic [8:0] encAttenCode,
	output logic [8:0] fskAttenCode,
	output logic coderDataOut,
	output logic pairLowOut,
	output logic pairHighOut,
	output logic pairValid,
	output logic signed [11:0] firOut,
	output logic lineDriverTx
);
	localparam int AW = $clog2(DEPTH);
	localparam int SHIFT_LEN = (`SYMBOL_DELAY_MS * BIT_RATE_HZ) / 1000;

	// Refuse settings the logic cannot serve
	initial begin
		if (DEPTH != 1024 || SAMPLE_W < 1 || SHIFT_LEN < 2 || REFRESH_CYCLES < 2 || LS_MIN_EDGES < 1) begin
			$error("simulcast_delay_path_control: unsupported parameters");
		end
	end

	// Reset release through two flip-flops
	logic rstMeta_q, rstSync_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	wire rst_n = rstSync_q;

	// Address decode, reused for every register
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	wire wrDelayLo = regWr && hit(regAddr, `REG_AUD_DELAY_LO);
	wire wrDelayHi = regWr && hit(regAddr, `REG_AUD_DELAY_HI);
	wire wrAudAtt = regWr && hit(regAddr, `REG_AUD_ATTEN);
	wire wrEncAtt = regWr && hit(regAddr, `REG_ENC_ATTEN);
	wire wrFskAtt = regWr && hit(regAddr, `REG_FSK_ATTEN);
	wire wrCtl = regWr && hit(regAddr, `REG_CONTROL);

	// Stored settings: the retained copy, written by software
	logic [7:0] storeDelayLo_q, storeDelayHiPend_q, storeAudAtt_q, storeEncAtt_q, storeFskAtt_q;
	logic [1:0] storeDelayHi_q;
	logic [1:0] halves_q;
	logic [7:0] ctl_q;
	wire commitDelay = (halves_q | {wrDelayHi, wrDelayLo}) == 2'b11;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			storeDelayLo_q <= 8'(`DELAY_RESET_VAL);
			storeDelayHi_q <= 2'h0;
			storeDelayHiPend_q <= 8'h00;
			halves_q <= 2'b00;
			storeAudAtt_q <= `ATTEN_RESET_VAL;
			storeEncAtt_q <= `ATTEN_RESET_VAL;
			storeFskAtt_q <= `ATTEN_RESET_VAL;
			ctl_q <= `CTL_RESET_VAL;
		end else begin
			if (wrDelayLo)
				storeDelayLo_q <= regWrData;
			if (wrDelayHi)
				storeDelayHiPend_q <= regWrData;
			if (commitDelay) begin
				storeDelayHi_q <= wrDelayHi ? regWrData[1:0] : storeDelayHiPend_q[1:0];
				halves_q <= 2'b00;
			end else begin
				halves_q <= halves_q | {wrDelayHi, wrDelayLo};
			end
			if (wrAudAtt)
				storeAudAtt_q <= regWrData;
			if (wrEncAtt)
				storeEncAtt_q <= regWrData;
			if (wrFskAtt)
				storeFskAtt_q <= regWrData;
			if (wrCtl)
				ctl_q <= regWrData;
		end
	end

	// Low delay byte only counts once its high half has joined it
	logic [7:0] committedLo_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			committedLo_q <= 8'h00;
		else if (commitDelay)
			committedLo_q <= wrDelayLo ? regWrData : storeDelayLo_q;
	end

	// Periodic refresh of the working latches from the store
	logic [$clog2(REFRESH_CYCLES)-1:0] refreshCnt_q;
	wire refreshTick = refreshCnt_q == ($clog2(REFRESH_CYCLES))'(REFRESH_CYCLES - 1);
	simulcast_pkg::delay_t delay_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			refreshCnt_q <= '0;
			delay_q <= `DELAY_RESET_VAL;
			audioAttenCode <= `ATTEN_OFFSET_STEPS;
			encAttenCode <= `ATTEN_OFFSET_STEPS;
			fskAttenCode <= `ATTEN_OFFSET_STEPS;
		end else begin
			refreshCnt_q <= refreshTick ? '0 : refreshCnt_q + 1'b1;
			if (refreshTick) begin
				delay_q <= {storeDelayHi_q, committedLo_q};
				audioAttenCode <= {1'b0, storeAudAtt_q} + `ATTEN_OFFSET_STEPS;
				encAttenCode <= {1'b0, storeEncAtt_q} + `ATTEN_OFFSET_STEPS;
				fskAttenCode <= {1'b0, storeFskAtt_q} + `ATTEN_OFFSET_STEPS;
			end
		end
	end

	// Circular sample queue
	logic [SAMPLE_W-1:0] queue_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	wire [AW-1:0] rdPtr = wrPtr_q - delay_q;
	always_ff @(posedge clk_sys) begin
		if (sampleStrobe)
			queue_q[wrPtr_q] <= sampleIn;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			sampleOut <= '0;
		end else if (sampleStrobe) begin
			wrPtr_q <= wrPtr_q + 1'b1;
			sampleOut <= delay_q == 10'h000 ? sampleIn : queue_q[rdPtr];
		end
	end

	// Key-up and data-detect from the monitored inputs
	wire talkActive = wide_area_talk_request || site_controller_talk_request;
	logic pairLocked_q;
	wire ddNext = data_detect_input && (!ctl_q[`CTL_FOUR_LEVEL] || pairLocked_q);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			transmitter_key_up_output <= 1'b0;
			data_detect_output <= 1'b0;
			encryptedSelect <= 1'b0;
			lineDriverTx <= 1'b0;
		end else begin
			transmitter_key_up_output <= talkActive || ctl_q[`CTL_REMOTE_KEY];
			data_detect_output <= ddNext;
			encryptedSelect <= ddNext;
			lineDriverTx <= ctl_q[`CTL_DRIVER_TX];
		end
	end

	// Lowspeed detector: count delayed FSK edges over each refresh window
	logic fskPrev_q, lowspeed_q;
	logic [3:0] edgeCnt_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fskPrev_q <= 1'b0;
			edgeCnt_q <= 4'h0;
			lowspeed_q <= 1'b0;
		end else begin
			fskPrev_q <= fskDelayedData;
			if (refreshTick) begin
				lowspeed_q <= edgeCnt_q >= 4'(LS_MIN_EDGES);
				edgeCnt_q <= 4'h0;
			end else if (fskPrev_q != fskDelayedData && edgeCnt_q != 4'hF) begin
				edgeCnt_q <= edgeCnt_q + 1'b1;
			end
		end
	end

	// Noise filter source selection
	simulcast_pkg::filter_e filtSel;
	assign filtSel = external_filter_jumper ? simulcast_pkg::FILT_FORCED
		: (control_channel_indicator_in || handshakeDataPresent) ? simulcast_pkg::FILT_OUT_EXT
		: (filter_source_jumper && !lowspeed_q) ? simulcast_pkg::FILT_OUT_INT
		: simulcast_pkg::FILT_IN;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			noiseFilterIn <= 1'b0;
		else
			noiseFilterIn <= filtSel == simulcast_pkg::FILT_IN;
	end

	// Two-level fixed delay line
	logic [SHIFT_LEN-1:0] shift_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			shift_q <= '0;
		else if (bitStrobe)
			shift_q <= {shift_q[SHIFT_LEN-2:0], symbol_low_bit_input};
	end

	// Di-bit pairing from the presignal boundary
	logic firstBit_q, heldBit_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pairLocked_q <= 1'b0;
			firstBit_q <= 1'b0;
			heldBit_q <= 1'b0;
			pairLowOut <= 1'b0;
			pairHighOut <= 1'b0;
			pairValid <= 1'b0;
			coderDataOut <= 1'b0;
		end else begin
			pairValid <= 1'b0;
			if (!ctl_q[`CTL_FOUR_LEVEL]) begin
				pairLocked_q <= 1'b0;
				firstBit_q <= 1'b0; // No stale half pair survives a mode change
			end else if (bitStrobe) begin
				coderDataOut <= symbol_low_bit_input;
				if (presignalSync) begin
					pairLocked_q <= 1'b1;
					heldBit_q <= symbol_low_bit_input;
					firstBit_q <= 1'b1;
				end else if (firstBit_q) begin
					pairHighOut <= heldBit_q;
					pairLowOut <= symbol_low_bit_input;
					pairValid <= 1'b1;
					firstBit_q <= 1'b0;
				end else if (pairLocked_q) begin
					heldBit_q <= symbol_low_bit_input;
					firstBit_q <= 1'b1;
				end
			end
		end
	end

	// Symbol level into the splatter filter
	function automatic simulcast_pkg::level_t encode4(input logic msb, input logic lsb);
		return 3'(signed'({1'b0, msb, lsb}) * 2 - 3);
	endfunction
	wire simulcast_pkg::level_t lvl2 = shift_q[SHIFT_LEN-1] ? 3'sd1 : -3'sd1;
	wire simulcast_pkg::level_t lvl4 = encode4(symbol_high_bit_input, symbol_low_bit_input);
	wire simulcast_pkg::level_t firIn = ctl_q[`CTL_FOUR_LEVEL] ? lvl4 : lvl2;

	// FIR taps and coefficients
	function automatic logic signed [5:0] coef(input int i);
		return 6'(i < `FIR_TAPS / 2 ? i + 1 : `FIR_TAPS - i);
	endfunction
	simulcast_pkg::level_t tap_q [`FIR_TAPS];
	logic signed [11:0] prod [`FIR_TAPS];
	logic signed [11:0] acc [`FIR_TAPS+1];
	assign acc[0] = 12'sh000;
	for (genvar g = 0; g < `FIR_TAPS; g++) begin : gTap
		assign prod[g] = 12'(tap_q[g]) * 12'(coef(g));
		assign acc[g+1] = acc[g] + prod[g];
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n)
				tap_q[g] <= 3'sd0;
			else if (bitStrobe)
				tap_q[g] <= (g == 0) ? firIn : tap_q[g == 0 ? 0 : g-1];
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			firOut <= 12'sh000;
		else
			firOut <= acc[`FIR_TAPS];
	end

	// Register read port, data stands one cycle after the strobe
	wire [7:0] status = {3'h0, lowspeed_q, pairLocked_q, |halves_q, data_detect_output,
		transmitter_key_up_output};
	wire [7:0] rdMux = hit(regAddr, `REG_AUD_DELAY_LO) ? committedLo_q
		: hit(regAddr, `REG_AUD_DELAY_HI) ? {6'h00, storeDelayHi_q}
		: hit(regAddr, `REG_AUD_ATTEN) ? storeAudAtt_q
		: hit(regAddr, `REG_ENC_ATTEN) ? storeEncAtt_q
		: hit(regAddr, `REG_FSK_ATTEN) ? storeFskAtt_q
		: hit(regAddr, `REG_CONTROL) ? ctl_q
		: hit(regAddr, `REG_STATUS) ? status : 8'h00;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			regRdData <= 8'h00;
		else
			regRdData <= regRd ? rdMux : 8'h00;
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence sBothHalves;
		(wrDelayLo && !halves_q[1]) ##1 !regWr ##1 wrDelayHi;
	endsequence

	a_delay_commit_both: assert property (sBothHalves |=> halves_q == 2'b00)
		else $error("delay halves not committed");
	a_key_up_hold: assert property (talkActive |=> transmitter_key_up_output)
		else $error("key-up missing while talk active");
	a_key_up_drop: assert property (!talkActive && !ctl_q[`CTL_REMOTE_KEY] |=> !transmitter_key_up_output)
		else $error("key-up stays without request");
	a_clear_path_sel: assert property (!data_detect_input |=> !encryptedSelect)
		else $error("encrypted path chosen without data detect");
	a_encrypt_path_sel: assert property (data_detect_input && !ctl_q[`CTL_FOUR_LEVEL] |=> encryptedSelect)
		else $error("selector disagrees with data detect");
	a_filter_forced_out: assert property (external_filter_jumper || control_channel_indicator_in |=> !noiseFilterIn)
		else $error("noise filter in while it must be out");
	a_atten_offset: assert property (refreshTick |=> audioAttenCode == {1'b0, $past(storeAudAtt_q)} + `ATTEN_OFFSET_STEPS)
		else $error("attenuator offset wrong");
	a_queue_trail: assert property (sampleStrobe |=> wrPtr_q == $past(wrPtr_q) + 1'b1)
		else $error("write pointer did not advance");
	a_read_one_cycle: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data outside its cycle");
	a_driver_follow: assert property (wrCtl ##1 1'b1 |=> lineDriverTx == $past(regWrData[`CTL_DRIVER_TX], 2))
		else $error("line driver does not follow control");
endmodule
`default_nettype wire

/* File: verification/modem_side_model.sv */
// Far-side model: modem sample stream and recovered symbol bit stream.
// Assumes the block's clock; drives every line just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module modem_side_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [1:0] bitMode,
	output logic sampleStrobe,
	output logic [11:0] sampleIn,
	output logic bitStrobe,
	output logic presignalSync,
	output logic symbol_low_bit_input,
	output logic symbol_high_bit_input
);
	integer seed = 22;
	int cnt = 0;
	logic sent = 1'b0;

	// Start from idle lines
	initial begin
		sampleStrobe = 1'b0;
		sampleIn = 12'h000;
		bitStrobe = 1'b0;
		presignalSync = 1'b0;
		symbol_low_bit_input = 1'b0;
		symbol_high_bit_input = 1'b0;
	end

	// Sample every third cycle, a bit every fourth; data lines churn between strobes
	// Mode 1 random paired bits, mode 2 all ones, mode 3 all zeros
	// The serial side offers no flow-control lines at all
	always @(posedge clk_sys) begin
		cnt <= cnt + 1;
		sampleStrobe <= run && (cnt % 3 == 0);
		sampleIn <= 12'($random(seed));
		bitStrobe <= (bitMode != 2'h0) && (cnt % 4 == 0);
		presignalSync <= (bitMode == 2'h1) && !sent && (cnt % 4 == 0);
		if (bitMode == 2'h0)
			sent <= 1'b0;
		else if (cnt % 4 == 0)
			sent <= 1'b1;
		symbol_low_bit_input <= (bitMode == 2'h1) ? 1'($random(seed)) : (bitMode == 2'h2);
		symbol_high_bit_input <= (bitMode == 2'h1) ? 1'($random(seed)) : (bitMode == 2'h2);
	end
endmodule
`default_nettype wire

/* File: verification/tb_simulcast_delay_path_control.sv */
// Self-checking bench: registers, delay queue, control outputs, filter, symbol paths.
// Assumes the design in src/ and the modem model; refresh shortened to 16 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "simulcast_consts.svh"
module tb_simulcast_delay_path_control;
	localparam int RC = 16;
	logic clk_sys = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic data_detect_input = 1'b0, wide_area_talk_request = 1'b0;
	logic site_controller_talk_request = 1'b0, control_channel_indicator_in = 1'b0;
	logic handshakeDataPresent = 1'b0, external_filter_jumper = 1'b0;
	logic filter_source_jumper = 1'b0, fskDelayedData = 1'b0, fskToggle = 1'b0;
	logic sampleRun = 1'b0, sampleChk = 1'b0, fourLevel = 1'b0;
	logic [1:0] bitMode = 2'h0;
	logic [7:0] regRdData;
	logic sampleStrobe, bitStrobe, presignalSync, symbol_low_bit_input, symbol_high_bit_input;
	logic [11:0] sampleIn, sampleOut;
	logic data_detect_output, transmitter_key_up_output, encryptedSelect, noiseFilterIn;
	logic coderDataOut, pairLowOut, pairHighOut, pairValid, lineDriverTx;
	logic [8:0] audioAttenCode, encAttenCode, fskAttenCode;
	logic signed [11:0] firOut;
	logic [11:0] hist[$];
	logic [7:0] att[3];
	logic sawStrobe = 1'b0, wantCoder = 1'b0, wantPair = 1'b0, locked = 1'b0, phase = 1'b0;
	logic expCoder, expHi, expLo, firstBit;
	int expDelay = 0;
	int nFail = 0;
	int nTests = 0;
	integer seed = 22;

	simulcast_delay_path_control #(.REFRESH_CYCLES(RC)) i_dut (
		.clk_sys, .arst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.sampleStrobe, .sampleIn, .sampleOut, .data_detect_input, .wide_area_talk_request,
		.site_controller_talk_request, .control_channel_indicator_in, .handshakeDataPresent,
		.external_filter_jumper, .filter_source_jumper, .fskDelayedData, .bitStrobe,
		.presignalSync, .symbol_low_bit_input, .symbol_high_bit_input, .data_detect_output,
		.transmitter_key_up_output, .encryptedSelect, .noiseFilterIn, .audioAttenCode,
		.encAttenCode, .fskAttenCode, .coderDataOut, .pairLowOut, .pairHighOut, .pairValid,
		.firOut, .lineDriverTx);

	modem_side_model i_modem (.clk_sys, .run(sampleRun), .bitMode, .sampleStrobe, .sampleIn,
		.bitStrobe, .presignalSync, .symbol_low_bit_input, .symbol_high_bit_input);

	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;

	// Compare and count
	task automatic check(input string what, input logic signed [31:0] seen, exp);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("Error %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task automatic endOfTest();
		$display("Checks %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Register port cycles: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(posedge clk_sys);
		check(what, regRdData, e);
	endtask

	// Noise filter state expected from jumpers, indicators and lowspeed
	function automatic logic filterIn(input logic j, ind, hs, src, ls);
		return !j && !ind && !hs && (!src || ls);
	endfunction

	// Lowspeed activity on the delayed FSK line
	always @(posedge clk_sys) if (fskToggle) fskDelayedData <= !fskDelayedData;

	// Delayed sample must be the one written expDelay strobes earlier
	always @(posedge clk_sys) begin
		if (sawStrobe && sampleChk && hist.size() > expDelay)
			check("sampleOut", sampleOut, hist[hist.size() - 1 - expDelay]);
		sawStrobe = sampleStrobe;
		if (sampleStrobe)
			hist.push_back(sampleIn);
	end

	// Predict coder bit and di-bit pairs from the strobed bits
	always @(posedge clk_sys) begin
		if (wantCoder)
			check("coderDataOut", coderDataOut, expCoder);
		if (fourLevel)
			check("pairValid", pairValid, wantPair);
		if (wantPair) begin
			check("pairHigh", pairHighOut, expHi);
			check("pairLow", pairLowOut, expLo);
		end
		wantCoder = bitStrobe && fourLevel;
		expCoder = symbol_low_bit_input;
		wantPair = 1'b0;
		if (!fourLevel)
			locked = 1'b0;
		else if (bitStrobe && (presignalSync || locked)) begin
			wantPair = locked && phase && !presignalSync;
			expHi = firstBit;
			expLo = symbol_low_bit_input;
			firstBit = symbol_low_bit_input;
			phase = presignalSync || !phase;
			locked = 1'b1;
		end
	end

	// Watchdog
	initial begin
		cyc(20000);
		nFail++;
		$display("Error watchdog expected finish seen timeout");
		endOfTest();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		cyc(5);
		sampleRun <= 1'b1;
		sampleChk <= 1'b1;
		check("audioAtten", audioAttenCode, 9'h03C);
		check("fskAtten", fskAttenCode, 9'h03C);
		rdChk("ctrl", `REG_CONTROL, 8'h00);
		wr(4'h1, 8'hA5);
		rdChk("unmapped", 4'h1, 8'h00);
		// Low half alone leaves delay at zero
		wr(`REG_AUD_DELAY_LO, 8'h05);
		rdChk("pending", `REG_STATUS, 8'h04);
		cyc(3 * RC);
		sampleChk <= 1'b0;
		wr(`REG_AUD_DELAY_HI, 8'h01);
		rdChk("committed", `REG_STATUS, 8'h00);
		rdChk("delayLo", `REG_AUD_DELAY_LO, 8'h05);
		rdChk("delayHi", `REG_AUD_DELAY_HI, 8'h01);
		// Same delay again with the two halves one idle cycle apart
		wr(`REG_AUD_DELAY_LO, 8'h05);
		wr(`REG_AUD_DELAY_HI, 8'h01);
		rdChk("recommit", `REG_STATUS, 8'h00);
		expDelay <= 'h105;
		cyc(900);
		sampleChk <= 1'b1;
		// Random attenuator settings, offset added at refresh
		for (int k = 0; k < 3; k++) begin
			att[k] = 8'($random(seed));
			wr(4'(`REG_AUD_ATTEN + k), att[k]);
		end
		cyc(3 * RC);
		check("audioAtten", audioAttenCode, att[0] + `ATTEN_OFFSET_STEPS);
		check("encAtten", encAttenCode, att[1] + `ATTEN_OFFSET_STEPS);
		check("fskAtten", fskAttenCode, att[2] + `ATTEN_OFFSET_STEPS);
		for (int k = 0; k < 3; k++)
			rdChk("attenStore", 4'(`REG_AUD_ATTEN + k), att[k]);
		// Random control inputs, external filter source
		for (int i = 0; i < 24; i++) begin
			{data_detect_input, wide_area_talk_request, site_controller_talk_request,
				control_channel_indicator_in, handshakeDataPresent,
				external_filter_jumper} <= 6'($random(seed));
			cyc(3);
			check("ddOut", data_detect_output, data_detect_input);
			check("encSel", encryptedSelect, data_detect_input);
			check("keyUp", transmitter_key_up_output,
				wide_area_talk_request | site_controller_talk_request);
			check("filter", noiseFilterIn, filterIn(external_filter_jumper,
				control_channel_indicator_in, handshakeDataPresent, 1'b0, 1'b0));
		end
		// Internal source follows lowspeed detection
		{data_detect_input, wide_area_talk_request, site_controller_talk_request} <= 3'h0;
		{control_channel_indicator_in, handshakeDataPresent, external_filter_jumper} <= 3'h0;
		filter_source_jumper <= 1'b1;
		fskToggle <= 1'b1;
		cyc(3 * RC);
		check("filterLs", noiseFilterIn, filterIn(1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
		fskToggle <= 1'b0;
		cyc(3 * RC);
		check("filterQuiet", noiseFilterIn, filterIn(1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
		// Line driver direction and remote key-up
		wr(`REG_CONTROL, 8'h06);
		cyc(2);
		check("lineTx", lineDriverTx, 1);
		check("remoteKey", transmitter_key_up_output, 1);
		wr(`REG_CONTROL, 8'h00);
		cyc(2);
		check("lineRx", lineDriverTx, 0);
		// Two-level steady levels through shift register and FIR
		bitMode <= 2'h2;
		cyc(600);
		check("fir2High", firOut, 210);
		bitMode <= 2'h3;
		cyc(600);
		check("fir2Low", firOut, -210);
		// Four-level: presignal, random pairs, then top symbol level
		bitMode <= 2'h0;
		wr(`REG_CONTROL, 8'h01);
		cyc(2);
		fourLevel <= 1'b1;
		bitMode <= 2'h1;
		cyc(400);
		bitMode <= 2'h2;
		cyc(600);
		check("fir4", firOut, 630);
		// Data detect in four-level mode once pairs are locked
		data_detect_input <= 1'b1;
		cyc(3);
		check("dd4", data_detect_output, 1);
		check("encSel4", encryptedSelect, 1);
		endOfTest();
	end
endmodule
`default_nettype wire
